/* File: icc_cmd_parser.sv */
// Byte stream parser turning serial commands into register requests
`timescale 1ns/10ps
module icc_cmd_parser (
    // Clock, reset and enable
    input  wire logic          clk,
    input  wire logic          rstSync_n,
    input  wire logic          ce,
    // Received command bytes
    input  wire logic          rxValid,
    input  wire logic [7:0]    rxByte,
    // Register request
    output icc_pkg::icc_req_type req
);

    typedef enum logic [1:0] {WAIT_OP, GET_ADDR, GET_DATA} icc_parse_type;

    icc_parse_type      state_reg;
    logic               isWrite_reg;
    logic [1:0]         count_reg;
    logic [15:0]        addr_reg;
    logic [23:0]        data_reg;
    icc_pkg::icc_req_type req_reg;

    // --------------------------------------------------------------
    // Command framing: opcode, two address bytes, then four data bytes on writes only
    // --------------------------------------------------------------
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            state_reg   <= WAIT_OP;
            isWrite_reg <= 1'b0;
            count_reg   <= 2'h0;
            addr_reg    <= 16'h0000;
            data_reg    <= 24'h000000;
            req_reg     <= '0;
        end else if (ce) begin
            req_reg.wr <= 1'b0;
            req_reg.rd <= 1'b0;
            if (rxValid) begin
                case (state_reg)
                    WAIT_OP: begin
                        count_reg <= 2'h0;
                        // Unknown opcodes are dropped
                        if (rxByte == icc_pkg::OP_WRITE) begin
                            isWrite_reg <= 1'b1;
                            state_reg   <= GET_ADDR;
                        end else if (rxByte == icc_pkg::OP_READ) begin
                            isWrite_reg <= 1'b0;
                            state_reg   <= GET_ADDR;
                        end
                    end
                    GET_ADDR: begin
                        addr_reg <= {addr_reg[7:0], rxByte};
                        if (count_reg == icc_pkg::ADDR_LAST) begin
                            count_reg <= 2'h0;
                            if (isWrite_reg) begin
                                state_reg <= GET_DATA;
                            end else begin
                                state_reg    <= WAIT_OP;
                                req_reg.rd   <= 1'b1;
                                req_reg.addr <= {addr_reg[7:0], rxByte};
                            end
                        end else begin
                            count_reg <= count_reg + 2'h1;
                        end
                    end
                    GET_DATA: begin
                        data_reg <= {data_reg[15:0], rxByte};
                        if (count_reg == icc_pkg::DATA_LAST) begin
                            state_reg    <= WAIT_OP;
                            req_reg.wr   <= 1'b1;
                            req_reg.addr <= addr_reg;
                            req_reg.data <= {data_reg, rxByte};
                        end else begin
                            count_reg <= count_reg + 2'h1;
                        end
                    end
                    default: begin
                        state_reg <= WAIT_OP;
                    end
                endcase
            end
        end
    end

    assign req = req_reg;

endmodule

/* File: icc_config_regs.sv */
// Configuration register bank of the pixel correction pipeline
`timescale 1ns/10ps
module icc_config_regs (
    // Clock, reset and enable
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  ce,
    // Serial command bytes
    input  wire logic                  rxValid,
    input  wire logic [7:0]            rxByte,
    // Read answer
    output logic [31:0]                rdData,
    output logic                       rdValid,
    // Gains computed by the balance engine
    input  wire icc_pkg::icc_gain_type computedGain,
    // Settings to the datapaths
    output icc_pkg::icc_cfg_type       cfg,
    output icc_pkg::icc_gain_type      appliedGain
);

    // --------------------------------------------------------------
    // Decoding helpers
    // --------------------------------------------------------------

    // Write hit on one register address
    function automatic logic hitWrite(input icc_pkg::icc_req_type r,
                                      input logic [15:0] a);
        hitWrite = r.wr && (r.addr == a);
    endfunction

    // Balance modes in which gains come from the engine
    function automatic logic usesComputed(input logic [2:0] m);
        usesComputed = (m == icc_pkg::BAL_ONCE) || (m == icc_pkg::BAL_AUTO);
    endfunction

    // --------------------------------------------------------------
    // Declarations
    // --------------------------------------------------------------
    logic [1:0]         rstPipe_reg;
    logic               rstSync_n;
    icc_pkg::icc_req_type req;
    logic               tableSel_reg;
    logic               tableOn_reg;
    logic [1:0]         defectMode_reg;
    logic [1:0]         hotMode_reg;
    logic [11:0]        defectThr_reg;
    logic [11:0]        hotThr_reg;
    logic               flatOn_reg;
    logic               flatUser_reg;
    logic               columnFix_reg;
    logic [2:0]         balMode_reg;
    logic [11:0]        gain_reg    [0:2];
    logic [11:0]        applied_reg [0:2];
    logic [11:0]        compArr     [0:2];
    logic [11:0]        gainRead    [0:2];
    logic [31:0]        rdWord;
    logic [31:0]        rdData_reg;
    logic               rdValid_reg;

    // --------------------------------------------------------------
    // Reset release through two flip-flops
    // --------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstPipe_reg <= 2'b00;
        end else begin
            rstPipe_reg <= {rstPipe_reg[0], 1'b1};
        end
    end

    assign rstSync_n = rstPipe_reg[1];

    // --------------------------------------------------------------
    // Command parser
    // --------------------------------------------------------------
    icc_cmd_parser u_parser (
        .clk       (clk),
        .rstSync_n (rstSync_n),
        .ce        (ce),
        .rxValid   (rxValid),
        .rxByte    (rxByte),
        .req       (req)
    );

    // --------------------------------------------------------------
    // Lookup table controls
    // --------------------------------------------------------------
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            tableSel_reg <= 1'b0;
            tableOn_reg  <= 1'b0;
        end else if (ce) begin
            if (hitWrite(req, icc_pkg::ADDR_TABLE_CHOICE)) begin
                tableSel_reg <= req.data[0];
            end
            if (hitWrite(req, icc_pkg::ADDR_TABLE_APPLY)) begin
                tableOn_reg <= req.data[0];
            end
        end
    end

    // --------------------------------------------------------------
    // Defect and hot pixel fix modes and thresholds
    // --------------------------------------------------------------
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            defectMode_reg <= icc_pkg::FIX_OFF;
            hotMode_reg    <= icc_pkg::FIX_OFF;
            defectThr_reg  <= icc_pkg::THR_RESET;
            hotThr_reg     <= icc_pkg::THR_RESET;
        end else if (ce) begin
            if (hitWrite(req, icc_pkg::ADDR_DEFECT_MODE)) begin
                defectMode_reg <= req.data[icc_pkg::FIX_W-1:0];
            end
            if (hitWrite(req, icc_pkg::ADDR_HOT_MODE)) begin
                hotMode_reg <= req.data[icc_pkg::FIX_W-1:0];
            end
            if (hitWrite(req, icc_pkg::ADDR_DEFECT_THR)) begin
                defectThr_reg <= req.data[icc_pkg::THR_W-1:0];
            end
            if (hitWrite(req, icc_pkg::ADDR_HOT_THR)) begin
                hotThr_reg <= req.data[icc_pkg::THR_W-1:0];
            end
        end
    end

    // --------------------------------------------------------------
    // Flat field and column noise controls
    // --------------------------------------------------------------
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            flatOn_reg    <= 1'b0;
            flatUser_reg  <= 1'b0;
            columnFix_reg <= 1'b0;
        end else if (ce) begin
            if (hitWrite(req, icc_pkg::ADDR_FLAT_ON)) begin
                flatOn_reg <= req.data[0];
            end
            if (hitWrite(req, icc_pkg::ADDR_FLAT_SOURCE)) begin
                flatUser_reg <= req.data[0];
            end
            if (hitWrite(req, icc_pkg::ADDR_COLUMN_FIX)) begin
                columnFix_reg <= req.data[0];
            end
        end
    end

    // --------------------------------------------------------------
    // Balance mode; reserved codes leave the mode unchanged
    // --------------------------------------------------------------
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            balMode_reg <= icc_pkg::BAL_OFF;
        end else if (ce) begin
            if (hitWrite(req, icc_pkg::ADDR_BALANCE_MODE) &&
                req.data[icc_pkg::BAL_W-1:0] <= icc_pkg::BAL_MANUAL) begin
                balMode_reg <= req.data[icc_pkg::BAL_W-1:0];
            end
        end
    end

    // --------------------------------------------------------------
    // Gain channels: stored, read back and applied
    // --------------------------------------------------------------
    assign compArr[0] = computedGain.red;
    assign compArr[1] = computedGain.green;
    assign compArr[2] = computedGain.blue;

    for (genvar ch = 0; ch < icc_pkg::GAIN_CHANNELS; ch++) begin : g_chan
        // Written coefficient, unsigned code of 1/256 steps
        always_ff @(posedge clk or negedge rstSync_n) begin
            if (!rstSync_n) begin
                gain_reg[ch] <= icc_pkg::GAIN_RESET;
            end else if (ce && hitWrite(req, icc_pkg::ADDR_GAIN[ch])) begin
                gain_reg[ch] <= req.data[icc_pkg::GAIN_W-1:0];
            end
        end

        // Engine value in once or auto, else the written one
        assign gainRead[ch] = usesComputed(balMode_reg) ?
                              compArr[ch] : gain_reg[ch];

        // Gain handed to the datapath
        always_ff @(posedge clk or negedge rstSync_n) begin
            if (!rstSync_n) begin
                applied_reg[ch] <= icc_pkg::GAIN_RESET;
            end else if (ce) begin
                applied_reg[ch] <= gainRead[ch];
            end
        end
    end

    // --------------------------------------------------------------
    // Read mux; unused bits and unmapped addresses read zero
    // --------------------------------------------------------------
    always_comb begin
        rdWord = 32'h00000000;
        case (req.addr)
            icc_pkg::ADDR_TABLE_CHOICE: rdWord[0]     = tableSel_reg;
            icc_pkg::ADDR_TABLE_APPLY:  rdWord[0]     = tableOn_reg;
            icc_pkg::ADDR_DEFECT_MODE:  rdWord[1:0]   = defectMode_reg;
            icc_pkg::ADDR_HOT_MODE:     rdWord[1:0]   = hotMode_reg;
            icc_pkg::ADDR_DEFECT_THR:   rdWord[11:0]  = defectThr_reg;
            icc_pkg::ADDR_HOT_THR:      rdWord[11:0]  = hotThr_reg;
            icc_pkg::ADDR_FLAT_ON:      rdWord[0]     = flatOn_reg;
            icc_pkg::ADDR_FLAT_SOURCE:  rdWord[0]     = flatUser_reg;
            icc_pkg::ADDR_COLUMN_FIX:   rdWord[0]     = columnFix_reg;
            icc_pkg::ADDR_BALANCE_MODE: rdWord[2:0]   = balMode_reg;
            icc_pkg::ADDR_GAIN[0]:      rdWord[11:0]  = gainRead[0];
            icc_pkg::ADDR_GAIN[1]:      rdWord[11:0]  = gainRead[1];
            icc_pkg::ADDR_GAIN[2]:      rdWord[11:0]  = gainRead[2];
            default:                    rdWord        = 32'h00000000;
        endcase
    end

    // --------------------------------------------------------------
    // Read answer register, one cycle after the request
    // --------------------------------------------------------------
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            rdData_reg  <= 32'h00000000;
            rdValid_reg <= 1'b0;
        end else if (ce) begin
            rdValid_reg <= req.rd;
            if (req.rd) begin
                rdData_reg <= rdWord;
            end
        end
    end

    // --------------------------------------------------------------
    // Outputs
    // --------------------------------------------------------------
    assign rdData              = rdData_reg;
    assign rdValid             = rdValid_reg;
    assign cfg.tableSel        = tableSel_reg;
    assign cfg.tableOn         = tableOn_reg;
    assign cfg.defectMode      = defectMode_reg;
    assign cfg.hotMode         = hotMode_reg;
    assign cfg.defectThr       = defectThr_reg;
    assign cfg.hotThr          = hotThr_reg;
    assign cfg.flatOn          = flatOn_reg;
    assign cfg.flatUser        = flatUser_reg;
    assign cfg.columnFixOn     = columnFix_reg;
    assign cfg.balanceMode     = balMode_reg;
    assign appliedGain.red     = applied_reg[0];
    assign appliedGain.green   = applied_reg[1];
    assign appliedGain.blue    = applied_reg[2];

    // --------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------

    // Manual mode: written red value reaches the datapath in two cycles
    property p_red_manual;
        @(posedge clk) disable iff (!rstSync_n)
        (ce && hitWrite(req, icc_pkg::ADDR_GAIN[0]) &&
         balMode_reg == icc_pkg::BAL_MANUAL) ##1 ce [*2]
        |-> appliedGain.red == $past(req.data[11:0], 2);
    endproperty
    a_red_manual: assert property (p_red_manual)
        else $error("red gain not applied in manual mode");

    // Auto mode: red read returns the engine value
    property p_red_auto;
        @(posedge clk) disable iff (!rstSync_n)
        (ce && req.rd && req.addr == icc_pkg::ADDR_GAIN[0] &&
         balMode_reg == icc_pkg::BAL_AUTO)
        |=> rdValid && rdData == {20'h00000, $past(computedGain.red)};
    endproperty
    a_red_auto: assert property (p_red_auto)
        else $error("red read not the computed gain");

    // Once mode: green applied from the engine
    property p_green_once;
        @(posedge clk) disable iff (!rstSync_n)
        (ce && balMode_reg == icc_pkg::BAL_ONCE)
        |=> appliedGain.green == $past(computedGain.green);
    endproperty
    a_green_once: assert property (p_green_once)
        else $error("green gain not taken from engine");

    // Manual mode: blue read returns the stored coefficient
    property p_blue_manual;
        @(posedge clk) disable iff (!rstSync_n)
        (ce && req.rd && req.addr == icc_pkg::ADDR_GAIN[2] &&
         balMode_reg == icc_pkg::BAL_MANUAL)
        |=> rdData[11:0] == $past(gain_reg[2]);
    endproperty
    a_blue_manual: assert property (p_blue_manual)
        else $error("blue read not the written gain");

    // Reserved balance codes leave the mode alone
    property p_bal_reserved;
        @(posedge clk) disable iff (!rstSync_n)
        (hitWrite(req, icc_pkg::ADDR_BALANCE_MODE) && req.data[2])
        |=> $stable(cfg.balanceMode);
    endproperty
    a_bal_reserved: assert property (p_bal_reserved)
        else $error("reserved balance code accepted");

    // Defect mode follows the low two data bits
    property p_defect_mode;
        @(posedge clk) disable iff (!rstSync_n)
        (ce && hitWrite(req, icc_pkg::ADDR_DEFECT_MODE))
        |=> cfg.defectMode == $past(req.data[1:0]);
    endproperty
    a_defect_mode: assert property (p_defect_mode)
        else $error("defect fix mode not stored");

    // Hot pixel threshold follows the low twelve data bits
    property p_hot_thr;
        @(posedge clk) disable iff (!rstSync_n)
        (ce && hitWrite(req, icc_pkg::ADDR_HOT_THR))
        |=> cfg.hotThr == $past(req.data[11:0]);
    endproperty
    a_hot_thr: assert property (p_hot_thr)
        else $error("hot threshold not stored");

    // Table select reads back as written, upper bits zero
    property p_table_read;
        @(posedge clk) disable iff (!rstSync_n)
        (ce && req.rd && req.addr == icc_pkg::ADDR_TABLE_CHOICE)
        |=> rdData == {31'h00000000, $past(tableSel_reg)};
    endproperty
    a_table_read: assert property (p_table_read)
        else $error("table select readback wrong");

    // Flat field source follows bit zero
    property p_flat_source;
        @(posedge clk) disable iff (!rstSync_n)
        (ce && hitWrite(req, icc_pkg::ADDR_FLAT_SOURCE))
        |=> cfg.flatUser == $past(req.data[0]);
    endproperty
    a_flat_source: assert property (p_flat_source)
        else $error("flat field source not stored");

endmodule

/* File: icc_pkg.sv */
// Constants, field layouts and carrier types of the correction config bank
package icc_pkg;

    // ------------------------------------------------------------------
    // Register byte addresses on the serial command channel
    // ------------------------------------------------------------------
    localparam logic [15:0] ADDR_TABLE_CHOICE   = 16'h0410;
    localparam logic [15:0] ADDR_TABLE_APPLY    = 16'h0414;
    localparam logic [15:0] ADDR_DEFECT_MODE    = 16'h0418;
    localparam logic [15:0] ADDR_HOT_MODE       = 16'h041C;
    localparam logic [15:0] ADDR_DEFECT_THR     = 16'h042C;
    localparam logic [15:0] ADDR_HOT_THR        = 16'h0430;
    localparam logic [15:0] ADDR_FLAT_SOURCE    = 16'h0434;
    localparam logic [15:0] ADDR_FLAT_ON        = 16'h0438;
    localparam logic [15:0] ADDR_COLUMN_FIX     = 16'h0440;
    localparam logic [15:0] ADDR_BALANCE_MODE   = 16'h0538;
    localparam int          GAIN_CHANNELS       = 3;
    localparam logic [15:0] ADDR_GAIN [0:2]     = '{16'h0540, 16'h0544,
                                                    16'h0548};

    // ------------------------------------------------------------------
    // Field widths and reset values
    // ------------------------------------------------------------------
    localparam int          GAIN_W              = 12;
    localparam int          THR_W               = 12;
    localparam int          FIX_W               = 2;
    localparam int          BAL_W               = 3;
    localparam logic [11:0] GAIN_RESET          = 12'h100;
    localparam logic [11:0] THR_RESET           = 12'h000;
    localparam logic [1:0]  FIX_OFF             = 2'h0;
    localparam logic [1:0]  FIX_STATIC          = 2'h1;
    localparam logic [1:0]  FIX_DYNAMIC         = 2'h2;
    localparam logic [1:0]  FIX_BOTH            = 2'h3;
    localparam logic [2:0]  BAL_OFF             = 3'h0;
    localparam logic [2:0]  BAL_ONCE            = 3'h1;
    localparam logic [2:0]  BAL_AUTO            = 3'h2;
    localparam logic [2:0]  BAL_MANUAL          = 3'h3;

    // ------------------------------------------------------------------
    // Serial command framing
    // ------------------------------------------------------------------
    localparam logic [7:0]  OP_WRITE            = 8'h57;
    localparam logic [7:0]  OP_READ             = 8'h52;
    localparam logic [1:0]  ADDR_LAST           = 2'h1;
    localparam logic [1:0]  DATA_LAST           = 2'h3;

    // Register access request from the command parser
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [31:0] data;
    } icc_req_type;

    // Per channel gain triple
    typedef struct packed {
        logic [11:0] red;
        logic [11:0] green;
        logic [11:0] blue;
    } icc_gain_type;

    // Settings handed to the correction datapaths
    typedef struct packed {
        logic        tableSel;
        logic        tableOn;
        logic [1:0]  defectMode;
        logic [1:0]  hotMode;
        logic [11:0] defectThr;
        logic [11:0] hotThr;
        logic        flatOn;
        logic        flatUser;
        logic        columnFixOn;
        logic [2:0]  balanceMode;
    } icc_cfg_type;

endpackage

/* File: test_image_correction_config_regs.sv */
// Self-checking bench of the correction config register bank
`timescale 1ns/10ps
module test_image_correction_config_regs;
    logic                  clk;
    logic                  rst_n;
    logic                  rxValid;
    logic [7:0]            rxByte;
    logic [31:0]           rdData;
    logic                  rdValid;
    icc_pkg::icc_gain_type computedGain;
    icc_pkg::icc_cfg_type  cfg;
    icc_pkg::icc_gain_type appliedGain;
    int                    errors;
    int                    check_count;
    logic [15:0]           addrTab [0:11];
    logic [31:0]           maskTab [0:11];
    logic [31:0]           pat;
    logic [11:0]           expGain;

    // ----------------------------------
    // Design under test and clock
    // ----------------------------------
    icc_config_regs dut_u (
        .clk(clk), .rst_n(rst_n), .ce(1'b1), .rxValid(rxValid),
        .rxByte(rxByte), .rdData(rdData), .rdValid(rdValid),
        .computedGain(computedGain), .cfg(cfg), .appliedGain(appliedGain));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // One command byte per cycle
    task automatic send(input logic [7:0] b);
        @(posedge clk);
        rxValid <= 1'b1;
        rxByte  <= b;
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        send(icc_pkg::OP_WRITE);
        send(a[15:8]);
        send(a[7:0]);
        for (int i = 3; i >= 0; i--) send(d[8*i +: 8]);
        @(posedge clk);
        rxValid <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    // Read with bounded wait for the answer strobe
    task automatic rd(input logic [15:0] a, input logic [31:0] exp);
        send(icc_pkg::OP_READ);
        send(a[15:8]);
        send(a[7:0]);
        @(posedge clk);
        rxValid <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            #1;
            if (rdValid === 1'b1) begin
                chk(rdData, exp);
                return;
            end
            @(posedge clk);
        end
        errors++;
        stop_test();
    endtask

    task automatic stop_test();
        $display("errors %0d check_count %0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        errors = 0;
        check_count = 0;
        rst_n = 1'b0;
        rxValid = 1'b0;
        rxByte = 8'h00;
        computedGain = '{12'h123, 12'h456, 12'h789};
        addrTab = '{16'h0410, 16'h0414, 16'h0418, 16'h041C, 16'h042C,
                    16'h0430, 16'h0434, 16'h0438, 16'h0440, 16'h0540,
                    16'h0544, 16'h0548};
        maskTab = '{32'h1, 32'h1, 32'h3, 32'h3, 32'hFFF, 32'hFFF, 32'h1,
                    32'h1, 32'h1, 32'hFFF, 32'hFFF, 32'hFFF};
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        // Reset values: gains unity, the rest zero
        for (int i = 0; i < 12; i++) rd(addrTab[i], (i > 8) ? 32'h100 : 32'h0);
        // All ones, then a mixed pattern; unused bits must read zero
        for (int p = 0; p < 2; p++) begin
            pat = p ? 32'hFFFFFA5A : 32'hFFFFFFFF;
            for (int i = 0; i < 12; i++) wr(addrTab[i], pat);
            for (int i = 0; i < 12; i++) rd(addrTab[i], pat & maskTab[i]);
        end
        // Settings reach the datapath outputs
        chk({31'h0, cfg.tableSel}, 32'h0);
        chk({30'h0, cfg.defectMode}, 32'h2);
        chk({30'h0, cfg.hotMode}, 32'h2);
        chk({20'h0, cfg.hotThr}, 32'hA5A);
        // Each balance mode: stored or computed gain
        for (int m = 0; m < 4; m++) begin
            wr(icc_pkg::ADDR_BALANCE_MODE, 32'(m));
            rd(icc_pkg::ADDR_BALANCE_MODE, 32'(m));
            expGain = (m == 1 || m == 2) ? 12'h789 : 12'hA5A;
            rd(16'h0548, {20'h0, expGain});
            chk({20'h0, appliedGain.blue}, {20'h0, expGain});
        end
        // Reserved mode ignored, unmapped address reads zero
        wr(icc_pkg::ADDR_BALANCE_MODE, 32'h5);
        rd(icc_pkg::ADDR_BALANCE_MODE, 32'h3);
        rd(16'h0500, 32'h0);
        stop_test();
    end
endmodule
